// file: logic/frt_cfg.svh
// Register map, field positions and reset values of the 16-bit timer core.
//
// Behaviour
// [R1] 16-bit up-counter advanced by the CPU clock divided by 2, 4 or 8.
// [R2] Primary and alternate byte pairs show one count; alternate low never clears.
// [R3] Writing either low byte forces the counter to FFFCh.
// [R4] Reset loads FFFCh in every mode; no other value is ever reloaded.
// [R5] High byte read first freezes the low byte until the low read.
// [R6] After a complete pair read, a lone low read returns the live byte.
// [R7] Wrap from FFFFh to 0000h sets the overflow flag in every mode.
// [R8] Interrupt only with enable set and CPU mask clear; otherwise pending.
// [R9] Overflow flag clears on status read while set, then primary low access.
// [R10] Counting continues unchanged while the processor waits.
// [R11] Halt freezes the count; reset restarts from FFFCh, wake-up resumes.
// [R12] Clock select code with both bits one picks the external input.
// [R13] Edge select bit picks rising or falling external transitions.
// [R14] External events are synchronised to the CPU clock before counting.
// [R15] External clock allows four CPU clock edges between active edges.
// [R16] An input whose pin is absent always reads as one.
// [R17] Timer instances share nothing and run in lockstep after reset.
// [R18] Codes 0, 1, 2 select divide by 2, 4 and 8.
`ifndef FRT_CFG_SVH
`define FRT_CFG_SVH

`define FRT_ADDR_W 8
`define FRT_OFF_COUNT_HIGH 8'h00
`define FRT_OFF_COUNT_LOW 8'h04
`define FRT_OFF_ALT_HIGH 8'h08
`define FRT_OFF_ALT_LOW 8'h0C
`define FRT_OFF_STATUS 8'h10
`define FRT_OFF_CONTROL_ONE 8'h14
`define FRT_OFF_CONTROL_TWO 8'h18

`define FRT_COUNT_RESET 16'hFFFC
`define FRT_COUNT_TOP 16'hFFFF

`define FRT_EVT_W 2
`define FRT_EVT_OVERFLOW 0
`define FRT_EVT_RELOAD 1
`define FRT_EVT_RESET 2'h0

`define FRT_SEL_LSB 0
`define FRT_EDGE_BIT 2
`define FRT_CTL2_RESET 3'h0
`define FRT_DIV_W 3

`define FRT_SEL_DIV2 2'h0
`define FRT_SEL_DIV4 2'h1
`define FRT_SEL_DIV8 2'h2
`define FRT_SEL_EXT 2'h3

`define FRT_RESP_OKAY 2'h0
`define FRT_RESP_SLVERR 2'h2

`endif

// file: logic/frt_pkg.sv
// Types shared by the timer core files.
`default_nettype none
package frt_pkg;
    // Clock select field of the second control register.
    typedef logic [1:0] clock_sel_t;
    // Read channel states of the register slave.
    typedef enum logic [1:0] {
        RD_IDLE = 2'b01,
        RD_RESP = 2'b10
    } rd_state_e;
    // Write channel states of the register slave.
    typedef enum logic [1:0] {
        WR_COLLECT = 2'b01,
        WR_RESP = 2'b10
    } wr_state_e;
endpackage
`default_nettype wire

// file: logic/frt_prescaler.sv
// Prescaler and external edge detector that produce the count tick.
`default_nettype none
`include "frt_cfg.svh"
module frt_prescaler
    import frt_pkg::*;
(
    input wire logic clk_i,
    input wire logic reset_i,
    input wire logic run_i,
    input wire logic restart_i,
    input wire clock_sel_t sel_i,
    input wire logic edge_rise_i,
    input wire logic ext_level_i,
    output logic tick_o
);

    logic [`FRT_DIV_W-1:0] div;
    logic [`FRT_DIV_W-1:0] next_div;
    logic ext_prev;
    logic next_ext_prev;
    logic ext_edge;

    // Active edge of the already synchronised external level.
    always_comb begin
        if (edge_rise_i) begin // [R13]
            ext_edge = ext_level_i & ~ext_prev;
        end else begin
            ext_edge = ~ext_level_i & ext_prev;
        end
    end

    // Tick selection: internal ratios or one tick per external edge.
    always_comb begin
        next_div = div;
        next_ext_prev = ext_level_i;
        tick_o = 1'b0;
        if (restart_i) begin
            next_div = '0;
        end else if (run_i) begin // [R11]
            next_div = div + 1'b1; // [R1]
            unique case (sel_i) // [R18]
                `FRT_SEL_DIV2: tick_o = div[0];
                `FRT_SEL_DIV4: tick_o = &div[1:0];
                `FRT_SEL_DIV8: tick_o = &div;
                `FRT_SEL_EXT: tick_o = ext_edge; // [R12]
            endcase
        end
    end

    // Divider restarts from zero on reset so twin timers stay aligned.
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            div <= '0; // [R17]
            ext_prev <= 1'b1;
        end else begin
            div <= next_div;
            ext_prev <= next_ext_prev;
        end
    end

endmodule
`default_nettype wire

// file: logic/frt_timer.sv
// Free-running 16-bit timer core with an AXI4-Lite register slave.
//
// The AXI4-Lite register port and the register addresses were decided locally.
`default_nettype none
`include "frt_cfg.svh"
module frt_timer
    import frt_pkg::*;
#(
    parameter bit EXT_PRESENT = 1'b1
) (
    input wire logic CLK_I,
    input wire logic RESET_I,
    input wire logic [`FRT_ADDR_W-1:0] S_AXI_AWADDR_I,
    input wire logic S_AXI_AWVALID_I,
    output logic S_AXI_AWREADY_O,
    input wire logic [31:0] S_AXI_WDATA_I,
    input wire logic [3:0] S_AXI_WSTRB_I,
    input wire logic S_AXI_WVALID_I,
    output logic S_AXI_WREADY_O,
    output logic [1:0] S_AXI_BRESP_O,
    output logic S_AXI_BVALID_O,
    input wire logic S_AXI_BREADY_I,
    input wire logic [`FRT_ADDR_W-1:0] S_AXI_ARADDR_I,
    input wire logic S_AXI_ARVALID_I,
    output logic S_AXI_ARREADY_O,
    output logic [31:0] S_AXI_RDATA_O,
    output logic [1:0] S_AXI_RRESP_O,
    output logic S_AXI_RVALID_O,
    input wire logic S_AXI_RREADY_I,
    input wire logic EXT_COUNT_INPUT_I,
    input wire logic CPU_IRQ_MASK_I,
    input wire logic HALT_I,
    output logic IRQ_O
);

    // -----------------------------------------------------------------
    // Register decode
    // -----------------------------------------------------------------

    // Returns one when the byte address names a register of this block.
    function automatic logic reg_hit(input logic [`FRT_ADDR_W-1:0] a);
        unique case (a)
            `FRT_OFF_COUNT_HIGH, `FRT_OFF_COUNT_LOW,
            `FRT_OFF_ALT_HIGH, `FRT_OFF_ALT_LOW,
            `FRT_OFF_STATUS, `FRT_OFF_CONTROL_ONE,
            `FRT_OFF_CONTROL_TWO: reg_hit = 1'b1;
            default: reg_hit = 1'b0;
        endcase
    endfunction

    // -----------------------------------------------------------------
    // State declarations
    // -----------------------------------------------------------------

    wr_state_e wr_state;
    wr_state_e next_wr_state;
    logic aw_held;
    logic next_aw_held;
    logic [`FRT_ADDR_W-1:0] aw_addr;
    logic [`FRT_ADDR_W-1:0] next_aw_addr;
    logic w_held;
    logic next_w_held;
    logic [7:0] w_byte;
    logic [7:0] next_w_byte;
    logic w_lane;
    logic next_w_lane;
    logic [1:0] bresp;
    logic [1:0] next_bresp;
    logic wr_fire;

    rd_state_e rd_state;
    rd_state_e next_rd_state;
    logic [31:0] rdata;
    logic [31:0] next_rdata;
    logic [1:0] rresp;
    logic [1:0] next_rresp;
    logic rd_fire;

    logic [15:0] count;
    logic [15:0] next_count;
    logic [7:0] low_buffer;
    logic [7:0] next_low_buffer;
    logic buffer_frozen;
    logic next_buffer_frozen;
    logic [`FRT_EVT_W-1:0] status;
    logic [`FRT_EVT_W-1:0] next_status;
    logic [`FRT_EVT_W-1:0] irq_enable;
    logic [`FRT_EVT_W-1:0] next_irq_enable;
    logic clear_armed;
    logic next_clear_armed;
    logic [2:0] control_two;
    logic [2:0] next_control_two;

    logic ext_meta;
    logic ext_sync;
    logic ext_level;
    logic tick;
    logic restart;
    logic wrap;
    logic wr_ok;
    logic [7:0] rd_value;

    // -----------------------------------------------------------------
    // External count input
    // -----------------------------------------------------------------

    // Two flip-flops bring the pin into the CPU clock domain.
    always_ff @(posedge CLK_I) begin
        if (RESET_I) begin
            ext_meta <= 1'b1;
            ext_sync <= 1'b1;
        end else begin
            ext_meta <= EXT_COUNT_INPUT_I; // [R14]
            ext_sync <= ext_meta;
        end
    end

    // A pin that is not bonded out reads as a steady one.
    assign ext_level = EXT_PRESENT ? ext_sync : 1'b1; // [R16]

    // -----------------------------------------------------------------
    // Prescaler
    // -----------------------------------------------------------------

    // Halt freezes prescaler and counter; wait has no effect here.
    frt_prescaler u_prescaler (
        .clk_i(CLK_I),
        .reset_i(RESET_I),
        .run_i(~HALT_I), // [R10]
        .restart_i(restart),
        .sel_i(control_two[`FRT_SEL_LSB +: 2]),
        .edge_rise_i(control_two[`FRT_EDGE_BIT]),
        .ext_level_i(ext_level),
        .tick_o(tick)
    );

    // -----------------------------------------------------------------
    // AXI4-Lite write channel
    // -----------------------------------------------------------------

    // Address and data are taken in either order; the write happens
    // once both are held, and the response waits for bready.
    always_comb begin
        next_wr_state = wr_state;
        next_aw_held = aw_held;
        next_aw_addr = aw_addr;
        next_w_held = w_held;
        next_w_byte = w_byte;
        next_w_lane = w_lane;
        next_bresp = bresp;
        wr_fire = 1'b0;
        unique case (wr_state)
            WR_COLLECT: begin
                if (S_AXI_AWVALID_I && !aw_held) begin
                    next_aw_held = 1'b1;
                    next_aw_addr = S_AXI_AWADDR_I;
                end
                if (S_AXI_WVALID_I && !w_held) begin
                    next_w_held = 1'b1;
                    next_w_byte = S_AXI_WDATA_I[7:0];
                    next_w_lane = S_AXI_WSTRB_I[0];
                end
                if (aw_held && w_held) begin
                    wr_fire = 1'b1;
                    next_aw_held = 1'b0;
                    next_w_held = 1'b0;
                    next_bresp = reg_hit(aw_addr) ? `FRT_RESP_OKAY
                                                  : `FRT_RESP_SLVERR;
                    next_wr_state = WR_RESP;
                end
            end
            WR_RESP: begin
                if (S_AXI_BREADY_I) begin
                    next_wr_state = WR_COLLECT;
                end
            end
        endcase
    end

    // Write channel registers.
    always_ff @(posedge CLK_I) begin
        if (RESET_I) begin
            wr_state <= WR_COLLECT;
            aw_held <= 1'b0;
            aw_addr <= '0;
            w_held <= 1'b0;
            w_byte <= 8'h00;
            w_lane <= 1'b0;
            bresp <= `FRT_RESP_OKAY;
        end else begin
            wr_state <= next_wr_state;
            aw_held <= next_aw_held;
            aw_addr <= next_aw_addr;
            w_held <= next_w_held;
            w_byte <= next_w_byte;
            w_lane <= next_w_lane;
            bresp <= next_bresp;
        end
    end

    assign S_AXI_AWREADY_O = (wr_state == WR_COLLECT) && !aw_held;
    assign S_AXI_WREADY_O = (wr_state == WR_COLLECT) && !w_held;
    assign S_AXI_BVALID_O = (wr_state == WR_RESP);
    assign S_AXI_BRESP_O = bresp;

    // Only lane zero carries register data; other lanes are ignored.
    assign wr_ok = wr_fire && w_lane;

    // -----------------------------------------------------------------
    // AXI4-Lite read channel
    // -----------------------------------------------------------------

    // One read at a time; data is registered on acceptance.
    always_comb begin
        next_rd_state = rd_state;
        next_rdata = rdata;
        next_rresp = rresp;
        rd_fire = 1'b0;
        unique case (rd_state)
            RD_IDLE: begin
                if (S_AXI_ARVALID_I) begin
                    rd_fire = 1'b1;
                    next_rdata = {24'h000000, rd_value};
                    next_rresp = reg_hit(S_AXI_ARADDR_I) ? `FRT_RESP_OKAY
                                                         : `FRT_RESP_SLVERR;
                    next_rd_state = RD_RESP;
                end
            end
            RD_RESP: begin
                if (S_AXI_RREADY_I) begin
                    next_rd_state = RD_IDLE;
                end
            end
        endcase
    end

    // Read channel registers.
    always_ff @(posedge CLK_I) begin
        if (RESET_I) begin
            rd_state <= RD_IDLE;
            rdata <= 32'h00000000;
            rresp <= `FRT_RESP_OKAY;
        end else begin
            rd_state <= next_rd_state;
            rdata <= next_rdata;
            rresp <= next_rresp;
        end
    end

    assign S_AXI_ARREADY_O = (rd_state == RD_IDLE);
    assign S_AXI_RVALID_O = (rd_state == RD_RESP);
    assign S_AXI_RDATA_O = rdata;
    assign S_AXI_RRESP_O = rresp;

    // Read data mux; low bytes return the frozen copy while one is held.
    always_comb begin
        unique case (S_AXI_ARADDR_I)
            `FRT_OFF_COUNT_HIGH, `FRT_OFF_ALT_HIGH: rd_value = count[15:8];
            `FRT_OFF_COUNT_LOW, `FRT_OFF_ALT_LOW: begin
                rd_value = buffer_frozen ? low_buffer // [R5]
                                         : count[7:0]; // [R6]
            end
            `FRT_OFF_STATUS: rd_value = {6'h00, status};
            `FRT_OFF_CONTROL_ONE: rd_value = {6'h00, irq_enable};
            `FRT_OFF_CONTROL_TWO: rd_value = {5'h00, control_two};
            default: rd_value = 8'h00;
        endcase
    end

    // -----------------------------------------------------------------
    // Counter, read buffer and flags
    // -----------------------------------------------------------------

    // Any accepted write to either low byte restarts the count.
    assign restart = wr_fire && ((aw_addr == `FRT_OFF_COUNT_LOW) ||
                                 (aw_addr == `FRT_OFF_ALT_LOW)); // [R3]

    // Roll-over from the top value on a tick.
    assign wrap = tick && !restart && (count == `FRT_COUNT_TOP);

    // Next state of the counter, buffer, flags and control registers.
    always_comb begin
        next_count = count;
        next_low_buffer = low_buffer;
        next_buffer_frozen = buffer_frozen;
        next_status = status;
        next_irq_enable = irq_enable;
        next_clear_armed = clear_armed;
        next_control_two = control_two;
        // Counting; the reload value is the only one ever loaded.
        if (restart) begin
            next_count = `FRT_COUNT_RESET; // [R4]
        end else if (tick) begin
            next_count = count + 16'h0001; // [R1]
        end
        // High byte read freezes the low byte once per sequence.
        if (rd_fire && ((S_AXI_ARADDR_I == `FRT_OFF_COUNT_HIGH) ||
                        (S_AXI_ARADDR_I == `FRT_OFF_ALT_HIGH))) begin
            if (!buffer_frozen) begin // [R5]
                next_low_buffer = count[7:0];
                next_buffer_frozen = 1'b1;
            end
        end
        // Low byte read of either pair completes the sequence.
        if (rd_fire && ((S_AXI_ARADDR_I == `FRT_OFF_COUNT_LOW) ||
                        (S_AXI_ARADDR_I == `FRT_OFF_ALT_LOW))) begin
            next_buffer_frozen = 1'b0; // [R6]
        end
        // First step of the flag clear: status read while set.
        if (rd_fire && (S_AXI_ARADDR_I == `FRT_OFF_STATUS) &&
            status[`FRT_EVT_OVERFLOW]) begin
            next_clear_armed = 1'b1; // [R9]
        end
        // Second step: any access to the primary low byte only.
        if (clear_armed &&
            ((rd_fire && (S_AXI_ARADDR_I == `FRT_OFF_COUNT_LOW)) ||
             (wr_fire && (aw_addr == `FRT_OFF_COUNT_LOW)))) begin
            next_status[`FRT_EVT_OVERFLOW] = 1'b0; // [R9] [R2]
            next_clear_armed = 1'b0;
        end
        // Reload event is cleared by writing a one to it.
        if (wr_ok && (aw_addr == `FRT_OFF_STATUS) &&
            w_byte[`FRT_EVT_RELOAD]) begin
            next_status[`FRT_EVT_RELOAD] = 1'b0;
        end
        // Control writes.
        if (wr_ok && (aw_addr == `FRT_OFF_CONTROL_ONE)) begin
            next_irq_enable = w_byte[`FRT_EVT_W-1:0];
        end
        if (wr_ok && (aw_addr == `FRT_OFF_CONTROL_TWO)) begin
            next_control_two = w_byte[2:0]; // [R12] [R13]
        end
        // Hardware sets come last so they win over a same-cycle clear.
        if (wrap) begin
            next_status[`FRT_EVT_OVERFLOW] = 1'b1; // [R7]
        end
        if (restart) begin
            next_status[`FRT_EVT_RELOAD] = 1'b1;
        end
    end

    // Counter and flag registers; reset restarts from the reload value.
    always_ff @(posedge CLK_I) begin
        if (RESET_I) begin
            count <= `FRT_COUNT_RESET; // [R4] [R11] [R17]
            low_buffer <= 8'h00;
            buffer_frozen <= 1'b0;
            status <= `FRT_EVT_RESET;
            irq_enable <= `FRT_EVT_RESET;
            clear_armed <= 1'b0;
            control_two <= `FRT_CTL2_RESET;
        end else begin
            count <= next_count;
            low_buffer <= next_low_buffer;
            buffer_frozen <= next_buffer_frozen;
            status <= next_status;
            irq_enable <= next_irq_enable;
            clear_armed <= next_clear_armed;
            control_two <= next_control_two;
        end
    end

    // -----------------------------------------------------------------
    // Interrupt
    // -----------------------------------------------------------------

    // Pending flags stay set, so the request appears once unmasked.
    always_ff @(posedge CLK_I) begin
        if (RESET_I) begin
            IRQ_O <= 1'b0;
        end else begin
            IRQ_O <= (|(status & irq_enable)) && !CPU_IRQ_MASK_I; // [R8]
        end
    end

endmodule
`default_nettype wire

// file: tb/frt_timer_sva.sv
// Concurrent checks on the ports of the timer core.
`default_nettype none
`include "frt_cfg.svh"
module frt_timer_sva #(
    parameter bit EXT_PRESENT = 1'h1
) (
    input wire logic CLK_I,
    input wire logic RESET_I,
    input wire logic S_AXI_AWVALID_I,
    input wire logic S_AXI_AWREADY_O,
    input wire logic S_AXI_WVALID_I,
    input wire logic S_AXI_WREADY_O,
    input wire logic [1:0] S_AXI_BRESP_O,
    input wire logic S_AXI_BVALID_O,
    input wire logic S_AXI_BREADY_I,
    input wire logic S_AXI_ARVALID_I,
    input wire logic S_AXI_ARREADY_O,
    input wire logic [31:0] S_AXI_RDATA_O,
    input wire logic S_AXI_RVALID_O,
    input wire logic S_AXI_RREADY_I,
    input wire logic CPU_IRQ_MASK_I,
    input wire logic IRQ_O
);
    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (RESET_I);
    // -----------------------------------------------------------------
    // Register bus and interrupt checks
    // -----------------------------------------------------------------
    // Answers stand until taken.
    a_bresp_holds: assert property (S_AXI_BVALID_O && !S_AXI_BREADY_I
        |=> S_AXI_BVALID_O && $stable(S_AXI_BRESP_O))
        else $error("bresp moved");
    a_rdata_holds: assert property (S_AXI_RVALID_O && !S_AXI_RREADY_I
        |=> S_AXI_RVALID_O && $stable(S_AXI_RDATA_O))
        else $error("rdata moved");
    // No take while answering.
    a_write_refused: assert property (S_AXI_BVALID_O
        |-> !S_AXI_AWREADY_O && !S_AXI_WREADY_O)
        else $error("write taken");
    a_read_refused: assert property (S_AXI_RVALID_O |-> !S_AXI_ARREADY_O)
        else $error("read taken");
    // Fixed answer latency.
    a_read_latency: assert property (S_AXI_ARVALID_I && S_AXI_ARREADY_O
        |=> S_AXI_RVALID_O)
        else $error("read late");
    a_write_latency: assert property (S_AXI_AWVALID_I && S_AXI_AWREADY_O
        && S_AXI_WVALID_I && S_AXI_WREADY_O
        |=> !S_AXI_BVALID_O ##1 S_AXI_BVALID_O)
        else $error("write late");
    // Byte-wide registers.
    a_byte_wide: assert property (S_AXI_RVALID_O
        |-> S_AXI_RDATA_O[31:8] == 24'h000000)
        else $error("upper bits set");
    // Mask holds the interrupt off.
    a_irq_masked: assert property (IRQ_O |-> !$past(CPU_IRQ_MASK_I))
        else $error("irq while masked");
    c_irq: cover property (IRQ_O);
    c_slverr: cover property (S_AXI_BVALID_O && S_AXI_BRESP_O == 2'h2);
    c_read: cover property (S_AXI_RVALID_O && S_AXI_RREADY_I);
endmodule
bind frt_timer frt_timer_sva #(.EXT_PRESENT(EXT_PRESENT)) i_sva (.*);
`default_nettype wire

// file: tb/frt_cpu_model.sv
// Behavioural CPU that reaches the timer registers over the bus.
`default_nettype none
`include "frt_cfg.svh"
module frt_cpu_model (
    input wire logic clk_i,
    output logic [`FRT_ADDR_W-1:0] awaddr_o,
    output logic awvalid_o,
    input wire logic awready_i,
    output logic [31:0] wdata_o,
    output logic [3:0] wstrb_o,
    output logic wvalid_o,
    input wire logic wready_i,
    input wire logic [1:0] bresp_i,
    input wire logic bvalid_i,
    output logic bready_o,
    output logic [`FRT_ADDR_W-1:0] araddr_o,
    output logic arvalid_o,
    input wire logic arready_i,
    input wire logic [31:0] rdata_i,
    input wire logic [1:0] rresp_i,
    input wire logic rvalid_i,
    output logic rready_o
);
    // Idle bus; answers taken at once.
    initial begin
        {awaddr_o, araddr_o, wdata_o} = '0;
        {awvalid_o, wvalid_o, arvalid_o} = 3'h0;
        wstrb_o = 4'hF;
        {bready_o, rready_o} = 2'h3;
    end
    // Write: both offered, each dropped when taken.
    task automatic wr(input logic [7:0] a, input logic [31:0] dv,
                      output logic [1:0] r);
        awaddr_o <= a;
        wdata_o <= dv;
        awvalid_o <= 1'h1;
        wvalid_o <= 1'h1;
        do begin
            @(posedge clk_i);
            if (awready_i) awvalid_o <= 1'h0;
            if (wready_i) wvalid_o <= 1'h0;
        end while (bvalid_i !== 1'h1);
        r = bresp_i;
    endtask
    // Read: address held until taken.
    task automatic rd(input logic [7:0] a, output logic [31:0] dv,
                      output logic [1:0] r);
        araddr_o <= a;
        arvalid_o <= 1'h1;
        do begin
            @(posedge clk_i);
            if (arready_i) arvalid_o <= 1'h0;
        end while (rvalid_i !== 1'h1);
        dv = rdata_i;
        r = rresp_i;
    endtask
endmodule
`default_nettype wire

// file: tb/free_running_timer_counter_tb_top.sv
// Self-checking bench for the timer core and its register slave.
`default_nettype none
`include "frt_cfg.svh"
module free_running_timer_counter_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'h0;
    logic rst = 1'h1;
    logic halt = 1'h1;
    logic mask = 1'h0;
    logic ext = 1'h0;
    logic [`FRT_ADDR_W-1:0] awaddr, araddr;
    logic awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready, irq;
    logic [31:0] wdata, rdata, d, l;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp, r;
    logic [15:0] v;
    int miscompares = 0;
    int checked = 0;
    int cycles = 0;
    // Clock at 40 MHz.
    always #12.5 clk = ~clk;
    frt_timer i_dut (.CLK_I(clk), .RESET_I(rst), .S_AXI_AWADDR_I(awaddr),
        .S_AXI_AWVALID_I(awvalid), .S_AXI_AWREADY_O(awready),
        .S_AXI_WDATA_I(wdata), .S_AXI_WSTRB_I(wstrb), .S_AXI_WVALID_I(wvalid),
        .S_AXI_WREADY_O(wready), .S_AXI_BRESP_O(bresp),
        .S_AXI_BVALID_O(bvalid), .S_AXI_BREADY_I(bready),
        .S_AXI_ARADDR_I(araddr), .S_AXI_ARVALID_I(arvalid),
        .S_AXI_ARREADY_O(arready), .S_AXI_RDATA_O(rdata),
        .S_AXI_RRESP_O(rresp), .S_AXI_RVALID_O(rvalid),
        .S_AXI_RREADY_I(rready), .EXT_COUNT_INPUT_I(ext),
        .CPU_IRQ_MASK_I(mask), .HALT_I(halt), .IRQ_O(irq));
    frt_cpu_model i_cpu (.clk_i(clk), .awaddr_o(awaddr), .awvalid_o(awvalid),
        .awready_i(awready), .wdata_o(wdata), .wstrb_o(wstrb),
        .wvalid_o(wvalid), .wready_i(wready), .bresp_i(bresp),
        .bvalid_i(bvalid), .bready_o(bready), .araddr_o(araddr),
        .arvalid_o(arvalid), .arready_i(arready), .rdata_i(rdata),
        .rresp_i(rresp), .rvalid_i(rvalid), .rready_o(rready));
    // -----------------------------------------------------------------
    // Shared tasks
    // -----------------------------------------------------------------
    task automatic close_out();
        $display("Checks %0d, mismatches %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            miscompares++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wrc(input logic [7:0] a, input logic [31:0] dv,
                       input logic [1:0] er = 2'h0);
        i_cpu.wr(a, dv, r);
        chk(32'(r), 32'(er));
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] e,
                       input logic [1:0] er = 2'h0);
        i_cpu.rd(a, d, r);
        chk(d, e);
        chk(32'(r), 32'(er));
    endtask
    // Reads a 16-bit count, high byte first.
    task automatic rd16(input logic [7:0] hi, output logic [15:0] cv);
        i_cpu.rd(hi, d, r);
        cv[15:8] = d[7:0];
        i_cpu.rd(hi + 8'h04, d, r);
        cv[7:0] = d[7:0];
    endtask
    // Runs the counter n cycles.
    task automatic run(input int n);
        halt <= 1'h0;
        repeat (n) @(posedge clk);
        halt <= 1'h1;
        @(posedge clk);
    endtask
    // Five pin pulses, eight cycles apart.
    task automatic pulses();
        for (int i = 0; i < 5; i++) begin
            ext <= 1'h1;
            repeat (4) @(posedge clk);
            ext <= 0;
            repeat (4) @(posedge clk);
        end
    endtask
    // Cuts a hung run short.
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            miscompares++;
            close_out();
        end
    end
    // -----------------------------------------------------------------
    // Main sequence
    // -----------------------------------------------------------------
    initial begin
        repeat (4) @(posedge clk);
        rst <= 1'h0;
        @(posedge clk);
        // Reset values, with the counter frozen.
        rd16(`FRT_OFF_COUNT_HIGH, v);
        chk(32'(v), 32'(`FRT_COUNT_RESET));
        rdc(`FRT_OFF_STATUS, 32'h0);
        rdc(`FRT_OFF_CONTROL_ONE, 32'h0);
        rdc(`FRT_OFF_CONTROL_TWO, 32'h0);
        wrc(`FRT_OFF_COUNT_HIGH, 32'h12);
        wrc(8'h1C, 32'h0, 2'h2);
        rdc(8'h1C, 32'h0, 2'h2);
        // Alternate low write reloads.
        run(4);
        wrc(`FRT_OFF_ALT_LOW, 32'h0);
        rd16(`FRT_OFF_COUNT_HIGH, v);
        chk(32'(v), 32'(`FRT_COUNT_RESET));
        rdc(`FRT_OFF_STATUS, 32'h2);
        wrc(`FRT_OFF_STATUS, 32'h2);
        // Frozen then live low byte.
        rdc(`FRT_OFF_COUNT_HIGH, 32'hFF);
        run(40);
        i_cpu.rd(`FRT_OFF_COUNT_HIGH, d, r);
        rdc(`FRT_OFF_COUNT_LOW, 32'hFC);
        rd16(`FRT_OFF_ALT_HIGH, v);
        l = 32'(v[7:0]);
        chk(32'(v inside {16'h000F, 16'h0010}), 32'h1);
        rdc(`FRT_OFF_COUNT_LOW, l);
        rdc(`FRT_OFF_STATUS, 32'h1);
        chk(32'(irq), 32'h0);
        wrc(`FRT_OFF_CONTROL_ONE, 32'h1);
        repeat (2) @(posedge clk);
        chk(32'(irq), 32'h1);
        mask <= 1'h1;
        repeat (2) @(posedge clk);
        chk(32'(irq), 32'h0);
        mask <= 1'h0;
        repeat (2) @(posedge clk);
        chk(32'(irq), 32'h1);
        // Two-step clear, alternate low exempt.
        rdc(`FRT_OFF_ALT_LOW, l);
        rdc(`FRT_OFF_STATUS, 32'h1);
        rdc(`FRT_OFF_COUNT_LOW, l);
        rdc(`FRT_OFF_STATUS, 32'h0);
        repeat (2) @(posedge clk);
        chk(32'(irq), 32'h0);
        // Sixteen ticks per ratio.
        for (int k = 0; k < 3; k++) begin
            wrc(`FRT_OFF_CONTROL_TWO, 32'(k));
            wrc(`FRT_OFF_COUNT_LOW, 32'h0);
            run(16 << (k + 1));
            rd16(`FRT_OFF_COUNT_HIGH, v);
            chk(32'(v inside {16'h000B, 16'h000C}), 32'h1);
        end
        // External pin, rising then falling edges.
        wrc(`FRT_OFF_CONTROL_TWO, 32'h7);
        wrc(`FRT_OFF_COUNT_LOW, 32'h0);
        halt <= 1'h0;
        pulses();
        run(8);
        rd16(`FRT_OFF_COUNT_HIGH, v);
        chk(32'(v), 32'h1);
        wrc(`FRT_OFF_CONTROL_TWO, 32'h3);
        halt <= 1'h0;
        pulses();
        run(8);
        rd16(`FRT_OFF_COUNT_HIGH, v);
        chk(32'(v), 32'h6);
        close_out();
    end
endmodule
`default_nettype wire
